// file: verilog/sbabt_defines.svh
`ifndef SBABT_DEFINES_SVH
`define SBABT_DEFINES_SVH

// register offsets
`define SBABT_CTRL_OFS     4'h0
`define SBABT_DATA_OFS     4'h1

// control register bit positions
`define SBABT_MODE_HI_BIT  7
`define SBABT_MODE_LO_BIT  6
`define SBABT_LOST_BIT     5
`define SBABT_CLKSEL_BIT   4
`define SBABT_DONE_BIT     3
`define SBABT_RUN_BIT      2
`define SBABT_OVF_BIT      1
`define SBABT_MSB_BIT      0

// reset values
`define SBABT_COUNT_RST    9'h000
`define SBABT_DIV_RST      2'h0
`define SBABT_RDATA_RST    8'h00

// counter limits and arbitration sample points
`define SBABT_COUNT_MAX    9'h1ff
`define SBABT_DIV_LAST     2'h3
`define SBABT_ARB_THR_BUS  9'h038
`define SBABT_ARB_THR_PRE  9'h008

`endif

// file: verilog/sbabt_pkg.sv
`default_nettype none

package sbabt_pkg;

    typedef enum logic [1:0] {
        MODE_IDLE = 2'b00,
        MODE_MEAS = 2'b01,
        MODE_ARB  = 2'b10,
        MODE_RSVD = 2'b11
    } sbabt_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN  = 2'b10,
        ST_HALT = 2'b11
    } sbabt_state_type;

    typedef struct packed {
        sbabt_mode_type mode;
        logic           clk_sel;
    } sbabt_ctrl_type;

    typedef struct packed {
        logic lost;
        logic done;
        logic ovf;
    } sbabt_flag_type;

endpackage

`default_nettype wire

// file: verilog/sbabt_core.sv
// The register addresses and the strobed register port were left to the implementer.
`include "sbabt_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sbabt_core
    import sbabt_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       resetn_in,
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output var  logic [7:0] rdata_out,
    input  wire logic       rx_pin_in,
    input  wire logic       internal_transmit_in,
    output logic            tx_pin_out,
    input  wire logic       prescaler_source_sel_in,
    input  wire logic       bus_presc_tick_in,
    input  wire logic       gen_presc_tick_in
);

    ////////////////////////////////////////////////////////////////////
    // declarations

    sbabt_ctrl_type  ctrl;
    sbabt_flag_type  flags;
    sbabt_state_type state;
    sbabt_state_type next_state;
    logic [8:0]      count;
    logic [1:0]      div;
    logic            rx_s1;
    logic            rx_s2;
    logic            rx_s3;
    logic            rx_lvl;
    logic            rx_prev;
    logic            tx_prev;
    logic            ctl_wr;
    logic            rx_fall;
    logic            rx_rise;
    logic            tx_rise;
    logic            tx_fall;
    logic            running;
    logic            presc_tick;
    logic            src_tick;
    logic            cnt_tick;
    logic            step;
    logic            meas_stop;
    logic            sample;
    logic            lost_evt;
    logic            ovf_evt;
    logic            arb_clear;
    logic [7:0]      ctrl_byte;

    // sample point of arbitration for a clock select
    function automatic logic [8:0] arb_thr(input logic sel);
        arb_thr = sel ? `SBABT_ARB_THR_PRE : `SBABT_ARB_THR_BUS;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // input conditioning

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_s3 <= 1'b1;
        end else begin
            rx_s1 <= rx_pin_in;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            rx_lvl  <= 1'b1;
            rx_prev <= 1'b1;
            tx_prev <= 1'b1;
        end else begin
            if (rx_s2 == rx_s3) begin
                rx_lvl <= rx_s3;
            end
            rx_prev <= rx_lvl;
            tx_prev <= internal_transmit_in;
        end
    end

    assign rx_fall = rx_prev & ~rx_lvl;
    assign rx_rise = ~rx_prev & rx_lvl;
    assign tx_rise = internal_transmit_in & ~tx_prev;
    assign tx_fall = ~internal_transmit_in & tx_prev;
    assign ctl_wr  = wr_in && (addr_in == `SBABT_CTRL_OFS);

    ////////////////////////////////////////////////////////////////////
    // counter clock

    assign presc_tick = prescaler_source_sel_in ? gen_presc_tick_in
                                                : bus_presc_tick_in;
    assign src_tick   = ctrl.clk_sel ? presc_tick : 1'b1;
    assign cnt_tick   = src_tick && (div == `SBABT_DIV_LAST);

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            div <= `SBABT_DIV_RST;
        end else if (ctl_wr || state != ST_RUN) begin
            div <= `SBABT_DIV_RST;
        end else if (src_tick) begin
            div <= div + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencing

    // running while armed and not overflowed
    assign running   = (state == ST_RUN) && !flags.ovf;
    // stop on next fall, stop on rise
    assign meas_stop = (ctrl.mode == MODE_MEAS) && (state == ST_RUN)
                       && (ctrl.clk_sel ? rx_rise : rx_fall);
    assign sample    = (ctrl.mode == MODE_ARB) && (state == ST_RUN)
                       && !tx_rise && !tx_fall
                       && (count == arb_thr(ctrl.clk_sel));
    assign lost_evt  = sample && !rx_lvl;
    // early transmit low, restart on rise
    assign arb_clear = (ctrl.mode == MODE_ARB)
                       && (tx_rise || (state == ST_RUN && tx_fall));
    assign step      = running && cnt_tick && !arb_clear && !meas_stop;
    assign ovf_evt   = step && (count == `SBABT_COUNT_MAX);

    always_comb begin
        next_state = state;
        if (ctl_wr) begin
            if (wdata_in[`SBABT_MODE_HI_BIT:`SBABT_MODE_LO_BIT] == 2'b00) begin
                next_state = ST_IDLE;
            end else begin
                next_state = ST_WAIT;
            end
        end else begin
            case (ctrl.mode)
                MODE_MEAS: begin
                    case (state)
                        ST_IDLE: begin
                            next_state = ST_WAIT;
                        end
                        ST_WAIT: begin
                            // start on fall, start while low
                            if (ctrl.clk_sel ? !rx_lvl : rx_fall) begin
                                next_state = ST_RUN;
                            end
                        end
                        ST_RUN: begin
                            if (meas_stop) begin
                                next_state = ST_HALT;
                            end
                        end
                        default: begin
                            next_state = state;
                        end
                    endcase
                end
                MODE_ARB: begin
                    if (tx_rise) begin
                        next_state = ST_RUN;
                    end else if (state == ST_RUN && tx_fall) begin
                        next_state = ST_WAIT;
                    end else if (sample) begin
                        next_state = ST_HALT;
                    end else if (state == ST_IDLE) begin
                        next_state = ST_WAIT;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // counter

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            count <= `SBABT_COUNT_RST;
        end else if (ctl_wr) begin
            count <= `SBABT_COUNT_RST;
        end else if (ctrl.mode == MODE_IDLE || ctrl.mode == MODE_RSVD) begin
            count <= `SBABT_COUNT_RST;
        end else if (arb_clear) begin
            count <= `SBABT_COUNT_RST;
        end else if (step) begin
            count <= count + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control and flags

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            ctrl.mode    <= MODE_IDLE;
            ctrl.clk_sel <= 1'b0;
        end else if (ctl_wr) begin
            ctrl.mode    <= sbabt_mode_type'(
                wdata_in[`SBABT_MODE_HI_BIT:`SBABT_MODE_LO_BIT]);
            ctrl.clk_sel <= wdata_in[`SBABT_CLKSEL_BIT];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            flags <= '0;
        end else begin
            // clear only by zero in upper mode bit
            if (lost_evt) begin
                flags.lost <= 1'b1;
            end else if (ctl_wr && !wdata_in[`SBABT_MODE_HI_BIT]) begin
                flags.lost <= 1'b0;
            end
            // set on finish, clear by write
            if (meas_stop) begin
                flags.done <= 1'b1;
            end else if (ctl_wr) begin
                flags.done <= 1'b0;
            end
            // set on overflow, clear by write
            if (ovf_evt) begin
                flags.ovf <= 1'b1;
            end else if (ctl_wr) begin
                flags.ovf <= 1'b0;
            end
        end
    end

    assign tx_pin_out = internal_transmit_in | flags.lost;

    ////////////////////////////////////////////////////////////////////
    // register read

    assign ctrl_byte = {ctrl.mode, flags.lost, ctrl.clk_sel,
                        flags.done, running, flags.ovf, count[8]};

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            rdata_out <= `SBABT_RDATA_RST;
        end else if (rd_in && addr_in == `SBABT_CTRL_OFS) begin
            rdata_out <= ctrl_byte;
        end else if (rd_in && addr_in == `SBABT_DATA_OFS) begin
            rdata_out <= count[7:0];
        end else begin
            rdata_out <= `SBABT_RDATA_RST;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    property p_idle_zero;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (ctrl.mode == MODE_IDLE) |-> (count == 9'h000) && !running;
    endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("idle mode with nonzero count");

    property p_ovf_clear;
        @(posedge core_clk_in) disable iff (!resetn_in)
        ctl_wr && !ovf_evt |=> !flags.ovf && count == 9'h000;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear)
        else $error("control write left overflow or count");

    property p_lost_tx;
        @(posedge core_clk_in) disable iff (!resetn_in)
        flags.lost |-> tx_pin_out;
    endproperty
    a_lost_tx: assert property (p_lost_tx)
        else $error("transmit pin not forced while lost");

    property p_lost_hold;
        @(posedge core_clk_in) disable iff (!resetn_in)
        flags.lost && !(ctl_wr && !wdata_in[`SBABT_MODE_HI_BIT])
        |=> flags.lost;
    endproperty
    a_lost_hold: assert property (p_lost_hold)
        else $error("lost flag dropped without clearing write");

    property p_done_set;
        @(posedge core_clk_in) disable iff (!resetn_in)
        meas_stop && !ctl_wr |=> flags.done && !running && $stable(count);
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("measurement end did not set done");

    property p_rd_data;
        @(posedge core_clk_in) disable iff (!resetn_in)
        rd_in && addr_in == `SBABT_DATA_OFS
        |=> rdata_out == $past(count[7:0]);
    endproperty
    a_rd_data: assert property (p_rd_data)
        else $error("data read does not return low count");

    property p_arb_restart;
        @(posedge core_clk_in) disable iff (!resetn_in)
        ctrl.mode == MODE_ARB && tx_rise && !ctl_wr
        |=> count == 9'h000 && state == ST_RUN;
    endproperty
    a_arb_restart: assert property (p_arb_restart)
        else $error("transmit rise did not restart counter");

    property p_arb_lost;
        @(posedge core_clk_in) disable iff (!resetn_in)
        ctrl.mode == MODE_ARB && state == ST_RUN && !tx_rise
        && !tx_fall && count == arb_thr(ctrl.clk_sel) && !rx_lvl
        |=> flags.lost;
    endproperty
    a_arb_lost: assert property (p_arb_lost)
        else $error("low sample did not set lost");

    property p_div4;
        @(posedge core_clk_in) disable iff (!resetn_in)
        running && !ctrl.clk_sel && !ctl_wr && !arb_clear
        && ctrl.mode == MODE_MEAS && !meas_stop && div == 2'h0
        ##1 running ##1 running ##1 running
        |-> $past(count, 3) == count;
    endproperty
    a_div4: assert property (p_div4)
        else $error("counter stepped faster than clock over four");

    property p_arb_early;
        @(posedge core_clk_in) disable iff (!resetn_in)
        ctrl.mode == MODE_ARB && state == ST_RUN && tx_fall
        && !ctl_wr |=> count == 9'h000 && state == ST_WAIT;
    endproperty
    a_arb_early: assert property (p_arb_early)
        else $error("early transmit low did not reset counter");

endmodule

`default_nettype wire

// file: bench/sbabt_bus_node.sv
`timescale 1ns/1ps
`default_nettype none

// other node on the shared single wire, pull-up idle
module sbabt_bus_node (
    input  wire logic tx_pin_in,
    input  wire logic pull_low_in,
    output logic      rx_pin_out
);
    // dominant low from either node
    assign rx_pin_out = tx_pin_in & ~pull_low_in;
endmodule

`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import sbabt_pkg::*;
    logic       clk, rst_n, wr, rd, itx, psel, btick, gtick, pull;
    logic       txp, rxp;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, rv, got;
    logic [8:0] cnt;
    int         n_fail, tests_run, seed, cyc, per, pcnt, t, i, st;

    sbabt_core dut (
        .core_clk_in             (clk),
        .resetn_in               (rst_n),
        .addr_in                 (addr),
        .wdata_in                (wdata),
        .wr_in                   (wr),
        .rd_in                   (rd),
        .rdata_out               (rdata),
        .rx_pin_in               (rxp),
        .internal_transmit_in    (itx),
        .tx_pin_out              (txp),
        .prescaler_source_sel_in (psel),
        .bus_presc_tick_in       (btick),
        .gen_presc_tick_in       (gtick)
    );

    sbabt_bus_node node (
        .tx_pin_in   (txp),
        .pull_low_in (pull),
        .rx_pin_out  (rxp)
    );

    always #25 clk = ~clk;

    ////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc <= cyc + 1;
        pcnt <= (pcnt >= per - 1) ? 0 : pcnt + 1;
        btick <= (pcnt == 0) && !psel;
        gtick <= (pcnt == 0) && psel;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////
    function automatic int exp_count(input int n, input int div);
        return n / (4 * div);
    endfunction

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [8:0] got, input logic [8:0] e);
        tests_run++;
        if (got !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, e);
        end
    endtask

    task automatic chk_near(input logic [8:0] got, input int e, input int tol);
        tests_run++;
        if (^got === 1'bx || got < e - tol || got > e + tol) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, e);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask

    task automatic rd_cnt(output logic [8:0] c);
        logic [7:0] hi;
        logic [7:0] lo;
        rd_reg(4'h0, hi);
        rd_reg(4'h1, lo);
        c = {hi[0], lo};
    endtask

    task automatic wait_to(input int n);
        while (cyc < n) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        seed = 76225;
        clk = 1'b0;
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        itx = 1'b1;
        psel = 1'b0;
        pull = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        btick = 1'b0;
        gtick = 1'b0;
        per = 1;
        pcnt = 0;
        cyc = 0;
        n_fail = 0;
        tests_run = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(4'h0, rv);
        chk(rv, 8'h00);
        rd_reg(4'h1, rv);
        chk(rv, 8'h00);
        wr_reg(4'h7, 8'hff);
        rd_reg(4'h7, rv);
        chk(rv, 8'h00);
        for (i = 0; i < 6; i++) begin
            rv = $random(seed);
            if (rv[7:6] == 2'b11) rv[7] = 1'b0;
            wr_reg(4'h0, rv);
            rd_reg(4'h0, got);
            chk(got & 8'hd0, rv & 8'hd0);
        end
        wr_reg(4'h0, 8'h00);
        rd_cnt(cnt);
        chk(cnt, 9'h000);
        $display("test registers done");

        // bit time with divide by four, fall to fall
        t = 40 + ($random(seed) & 255);
        wr_reg(4'h0, 8'h40);
        pull <= 1'b1;
        st = cyc;
        repeat (20) @(posedge clk);
        rd_reg(4'h0, rv);
        chk(rv & 8'h04, 8'h04);
        pull <= 1'b0;
        wait_to(st + t);
        pull <= 1'b1;
        repeat (12) @(posedge clk);
        pull <= 1'b0;
        rd_cnt(cnt);
        chk_near(cnt, exp_count(t, 1), 1);
        rd_reg(4'h0, rv);
        chk(rv & 8'h0c, 8'h08);
        wr_reg(4'h0, 8'h40);
        rd_reg(4'h0, rv);
        chk(rv & 8'h0f, 8'h00);
        $display("test measure fall done");

        // break length on prescaler ticks, low at enable
        per = 1 + (($random(seed) & 32'h7fff) % 3);
        psel <= $random(seed);
        t = 100 + ($random(seed) & 255);
        wr_reg(4'h0, 8'h00);
        pull <= 1'b1;
        repeat (8) @(posedge clk);
        wr_reg(4'h0, 8'h50);
        st = cyc;
        wait_to(st + t);
        pull <= 1'b0;
        repeat (12) @(posedge clk);
        rd_cnt(cnt);
        chk_near(cnt, exp_count(t, per), 2);
        rd_reg(4'h0, rv);
        chk(rv & 8'h0c, 8'h08);
        $display("test measure break done");

        // overflow of a long bit time
        wr_reg(4'h0, 8'h40);
        pull <= 1'b1;
        st = cyc;
        repeat (8) @(posedge clk);
        pull <= 1'b0;
        wait_to(st + 2200);
        pull <= 1'b1;
        repeat (12) @(posedge clk);
        pull <= 1'b0;
        rd_cnt(cnt);
        chk(cnt, 9'h000);
        rd_reg(4'h0, rv);
        chk(rv & 8'h06, 8'h02);
        wr_reg(4'h0, 8'h00);
        rd_reg(4'h0, rv);
        chk(rv & 8'h02, 8'h00);
        $display("test overflow done");

        // arbitration lost against a dominant node
        for (i = 0; i < 2; i++) begin
            itx <= 1'b0;
            wr_reg(4'h0, i ? 8'h90 : 8'h80);
            itx <= 1'b1;
            pull <= 1'b1;
            repeat (i ? 32 * per + 24 : 244) @(posedge clk);
            rd_reg(4'h0, rv);
            chk(rv & 8'h20, 8'h20);
            itx <= 1'b0;
            repeat (2) @(posedge clk);
            chk({8'h00, txp}, 9'h001);
            wr_reg(4'h0, i ? 8'h90 : 8'h80);
            rd_reg(4'h0, rv);
            chk(rv & 8'h20, 8'h20);
            wr_reg(4'h0, 8'h00);
            rd_reg(4'h0, rv);
            chk(rv & 8'h20, 8'h00);
            pull <= 1'b0;
        end
        $display("test arbitration lost done");

        // transmit low before any low sensed, then clean frame
        itx <= 1'b0;
        wr_reg(4'h0, 8'h80);
        itx <= 1'b1;
        repeat (40) @(posedge clk);
        itx <= 1'b0;
        repeat (8) @(posedge clk);
        rd_cnt(cnt);
        chk(cnt, 9'h000);
        itx <= 1'b1;
        repeat (20) @(posedge clk);
        rd_reg(4'h0, rv);
        chk(rv & 8'h04, 8'h04);
        repeat (250) @(posedge clk);
        rd_reg(4'h0, rv);
        chk(rv & 8'h20, 8'h00);
        $display("test arbitration restart done");
        print_verdict();
    end
endmodule

`default_nettype wire
